// *** apm_pkg.sv ***
// Purpose: shared constants and types of the position mapping monitor
// Assumes: 40 MHz clock, APB register access with 32-bit data
// Notes: positions are signed increments in the scaled user unit
package apm_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_DIR = 8'h08;
	localparam logic [7:0] A_NUM = 8'h0C;
	localparam logic [7:0] A_DEN = 8'h10;
	localparam logic [7:0] A_REF = 8'h14;
	localparam logic [7:0] A_END = 8'h18;
	localparam logic [7:0] A_ULIM = 8'h1C;
	localparam logic [7:0] A_LLIM = 8'h20;
	localparam logic [7:0] A_WIN = 8'h24;
	localparam logic [7:0] A_LOOP = 8'h28;
	localparam logic [7:0] A_THR = 8'h2C;
	localparam logic [7:0] A_CORR = 8'h30;
	localparam logic [7:0] A_TGT = 8'h34;
	localparam logic [7:0] A_ACT = 8'h38;
	localparam logic [7:0] A_SAVE = 8'h3C;
	localparam logic [7:0] A_FAULT = 8'h40;
	localparam logic [7:0] A_BDLY = 8'h44;
	localparam logic [7:0] A_SPCT = 8'h48;
	localparam logic [7:0] A_SMS = 8'h4C;
	localparam logic [7:0] A_BTYPE = 8'h50;
	localparam logic [7:0] A_SPR = 8'h54;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int C_REL = 4;
	localparam int S_DRAG = 8;
	localparam int S_MOVE = 6;
	localparam int S_ERR = 10;
	// ****************************************************************
	// value table indices and delivery values
	// ****************************************************************
	localparam logic [2:0] V_TGT = 3'h0;
	localparam logic [2:0] V_REF = 3'h1;
	localparam logic [2:0] V_END = 3'h2;
	localparam logic [2:0] V_ULIM = 3'h3;
	localparam logic [2:0] V_LLIM = 3'h4;
	localparam logic [2:0] V_WIN = 3'h5;
	localparam logic [2:0] V_LOOP = 3'h6;
	localparam logic [2:0] V_THR = 3'h7;
	localparam logic [13:0] FACT_DEF = 14'h0190;
	localparam logic [13:0] FACT_MAX = 14'h2710;
	localparam logic [31:0] SPR_BASE = 32'h0000_0190;
	localparam logic signed [31:0] END_DEF = 32'h0001_9000;
	localparam logic signed [31:0] ULIM_DEF = 32'h0001_8B50;
	localparam logic signed [31:0] LLIM_DEF = 32'h0000_04B0;
	localparam logic signed [31:0] WIN_DEF = 32'h0000_0004;
	localparam logic signed [31:0] LOOP_DEF = 32'hFFFF_FF9C;
	localparam logic signed [31:0] THR_DEF = 32'h0000_0190;
	localparam logic signed [31:0] TGT_DEF = 32'h0000_C800;
	localparam logic [7:0] ROT_HI = 8'h03;
	localparam logic [7:0] ROT_LO = 8'hFD;
	localparam logic [1:0] FLT_ABORT = 2'h1;
	localparam logic [15:0] BDLY_MS = 16'h03E8;
	localparam logic [7:0] SPCT_DEF = 8'h1E;
	localparam logic [15:0] SMS_DEF = 16'h00C8;
	localparam int unsigned BWAIT_US = 20;
	localparam int unsigned BWAIT_CYC = (BWAIT_US * (CLK_HZ / 1_000_000) > 0) ?
		BWAIT_US * (CLK_HZ / 1_000_000) : 1;
	localparam logic [5:0] DIV_STEPS = 6'h2E;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		RS_IDLE = 3'b000,
		RS_WAIT = 3'b001,
		RS_UNLK = 3'b010,
		RS_RUN = 3'b011,
		RS_HOLD = 3'b100
	} apm_run_type;
	typedef enum logic [1:0] {BK_NONE = 2'b00, BK_HOLD = 2'b01, BK_FRIC = 2'b10} apm_brake_type;
	typedef struct packed {
		logic [4:0] ctrl;
		logic dir;
		logic [13:0] num;
		logic [13:0] den;
		logic [7:0][31:0] vals;
		logic [15:0] corr;
		logic save_busy;
		logic [1:0] fault;
		logic [15:0] bdly;
		logic [7:0] spct;
		logic [15:0] sms;
		apm_brake_type btype;
		logic [31:0] spr;
		logic drag_err;
		logic pos_err;
		logic busy;
		logic [3:0] idx;
		logic [5:0] bitc;
		logic [45:0] dq;
		logic [13:0] rem;
		logic neg;
		logic [13:0] sm;
		logic [13:0] sd;
		apm_run_type rs;
		logic [31:0] cnt;
		logic [31:0] mscnt;
		logic [15:0] stall_ms;
		logic [31:0] bk_start;
		logic [15:0] speed;
		logic [31:0] prdata;
	} apm_state_type;
endpackage

// *** apm_core.sv ***
// Purpose: position mapping, rescaling, save handshake, drag and run supervision
// Assumes: APB slave, positions from the motion core in scaled increments
// Notes: one state struct, one comb fill, one register stage
//
// Behaviour
// - target clamped 3 to 253 rotations below end
// - delivery factors 400, offset 0
// - direction change restores offset, end, limits
// - end write derives both limits
// - factor change rescales all dependent values
// - offset change shifts target, end, limits
// - save reads 1 until done, then 0
// - actual write sets offset from physical position
// - steps per rev is 400*num/den
// - factors accepted only from 1 to 10000
// - drag error flagged when lag exceeds threshold
// - zero threshold disables drag monitoring
// - speed corrected by lag times factor over 256
// - drag logic suspended while braking
// - comm timeout aborts run when reaction 01
// - run may resume once data valid again
// - holding brake waits, backs off, then runs
// - holding brake engages after configurable delay
// - friction brake idles first, releases at end
// - abort when speed stays below fraction too long
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module apm_core import apm_pkg::*; #(
	parameter int unsigned MS_CYC = CLK_HZ / 1000,
	parameter int unsigned BACKOFF = 4
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic resetn_i, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	input wire logic signed [31:0] phys_pos_i, // physical position
	input wire logic signed [31:0] cmd_pos_i, // profile target position
	input wire logic [15:0] speed_i, // actual speed
	input wire logic [15:0] tgt_speed_i, // configured target speed
	input wire logic braking_i, // motion core is braking
	input wire logic motion_done_i, // run finished
	input wire logic comm_timeout_i, // master communication lost
	input wire logic save_done_i, // non-volatile save finished
	output logic run_o, // motion enabled
	output logic reverse_o, // brake back-off move
	output logic brake_engage_o, // brake applied
	output logic save_req_o, // save request level
	output logic [15:0] speed_cmd_o, // corrected speed command
	output logic signed [31:0] target_o // clamped target
);
	initial begin
		if (MS_CYC < 1 || BACKOFF < 1) $error("bad apm_core parameter");
	end

	apm_state_type s_ff, nxt_s;
	logic acc, wr, hit, fact_ok;
	logic [13:0] wfact;
	logic signed [31:0] actual, ref_new, delta, rot3, rot253, diff, adiff;
	logic signed [31:0] div_src;
	logic [31:0] div_mag, rdata;
	logic [13:0] div_mul, div_den;
	logic [14:0] trial;
	logic abort, stall_low, run_req, drag_on;
	logic signed [47:0] corr_prod;
	logic signed [33:0] spd_sum;

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign pready = ~s_ff.busy;
	assign acc = psel & penable & pready;
	assign wfact = pwdata[13:0];
	assign fact_ok = (pwdata[31:14] == 18'h0_0000) && (wfact != 14'h0000) && (wfact <= FACT_MAX);
	assign hit = (paddr[1:0] == 2'b00) && (paddr <= A_SPR);
	assign wr = acc & pwrite & hit & ~(((paddr == A_NUM) || (paddr == A_DEN)) & ~fact_ok);
	assign pslverr = acc & ~(hit & ~(pwrite & ((paddr == A_NUM) || (paddr == A_DEN)) & ~fact_ok));
	assign prdata = s_ff.prdata;
	assign actual = phys_pos_i + $signed(s_ff.vals[V_REF]);
	assign rot3 = $signed(32'(s_ff.spr * 32'(ROT_HI)));
	assign rot253 = $signed(32'(s_ff.spr * 32'(ROT_LO)));
	assign ref_new = (paddr == A_ACT) ? $signed(pwdata) - phys_pos_i : $signed(pwdata);
	assign delta = ref_new - $signed(s_ff.vals[V_REF]);

	always_comb begin
		rdata = 32'h0000_0000;
		case (paddr)
			A_CTRL: rdata = {27'h000_0000, s_ff.ctrl};
			A_STAT: begin
				rdata[S_DRAG] = s_ff.drag_err;
				rdata[S_MOVE] = (s_ff.rs == RS_RUN) || (s_ff.rs == RS_UNLK);
				rdata[S_ERR] = s_ff.pos_err;
			end
			A_DIR: rdata = {31'h0000_0000, s_ff.dir};
			A_NUM: rdata = {18'h0_0000, s_ff.num};
			A_DEN: rdata = {18'h0_0000, s_ff.den};
			A_REF: rdata = s_ff.vals[V_REF];
			A_END: rdata = s_ff.vals[V_END];
			A_ULIM: rdata = s_ff.vals[V_ULIM];
			A_LLIM: rdata = s_ff.vals[V_LLIM];
			A_WIN: rdata = s_ff.vals[V_WIN];
			A_LOOP: rdata = s_ff.vals[V_LOOP];
			A_THR: rdata = s_ff.vals[V_THR];
			A_CORR: rdata = {16'h0000, s_ff.corr};
			A_TGT: rdata = s_ff.vals[V_TGT];
			A_ACT: rdata = actual;
			A_SAVE: rdata = {31'h0000_0000, s_ff.save_busy};
			A_FAULT: rdata = {30'h0000_0000, s_ff.fault};
			A_BDLY: rdata = {16'h0000, s_ff.bdly};
			A_SPCT: rdata = {24'h00_0000, s_ff.spct};
			A_SMS: rdata = {16'h0000, s_ff.sms};
			A_BTYPE: rdata = {30'h0000_0000, s_ff.btype};
			A_SPR: rdata = s_ff.spr;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************************************
	// shared rescale divider operands
	// ****************************************************************
	// last entry yields steps per revolution
	assign div_src = (s_ff.idx == 4'h8) ? $signed(SPR_BASE) : $signed(s_ff.vals[s_ff.idx[2:0]]);
	assign div_mul = (s_ff.idx == 4'h8) ? s_ff.num : s_ff.sm;
	assign div_den = (s_ff.idx == 4'h8) ? s_ff.den : s_ff.sd;
	assign div_mag = div_src[31] ? 32'(-div_src) : 32'(div_src);
	assign trial = {s_ff.rem, s_ff.dq[45]};

	// ****************************************************************
	// supervision terms
	// ****************************************************************
	assign diff = cmd_pos_i - actual;
	assign adiff = diff[31] ? -diff : diff;
	assign drag_on = (s_ff.rs == RS_RUN) & ~braking_i;
	assign stall_low = (32'(speed_i) * 32'd100) < (32'(s_ff.spct) * 32'(tgt_speed_i));
	assign run_req = s_ff.ctrl[C_REL] & (|s_ff.ctrl[2:0]);
	assign abort = ~s_ff.ctrl[C_REL] | (comm_timeout_i & (s_ff.fault == FLT_ABORT)) |
		((s_ff.stall_ms > s_ff.sms) & stall_low);
	assign corr_prod = 48'(diff) * $signed({1'b0, s_ff.corr});
	assign spd_sum = 34'(tgt_speed_i) + 34'(corr_prod >>> 8);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_s = s_ff;
		if (psel) begin
			nxt_s.prdata = rdata;
		end
		nxt_s.mscnt = (s_ff.mscnt >= 32'(MS_CYC - 1)) ? 32'h0000_0000 : s_ff.mscnt + 32'h0000_0001;
		if (save_done_i) begin
			nxt_s.save_busy = 1'b0;
		end
		if (wr) begin
			case (paddr)
				A_CTRL: nxt_s.ctrl = pwdata[4:0];
				A_STAT: begin
					if (pwdata[S_DRAG]) nxt_s.drag_err = 1'b0;
					if (pwdata[S_ERR]) nxt_s.pos_err = 1'b0;
				end
				A_DIR: begin
					nxt_s.dir = pwdata[0];
					if (pwdata[0] != s_ff.dir) begin
						nxt_s.vals[V_REF] = 32'h0000_0000;
						nxt_s.vals[V_END] = END_DEF;
						nxt_s.vals[V_ULIM] = ULIM_DEF;
						nxt_s.vals[V_LLIM] = LLIM_DEF;
					end
				end
				A_NUM, A_DEN: begin
					nxt_s.sm = (paddr == A_NUM) ? wfact : s_ff.den;
					nxt_s.sd = (paddr == A_NUM) ? s_ff.num : wfact;
					if (paddr == A_NUM) nxt_s.num = wfact;
					else nxt_s.den = wfact;
					nxt_s.busy = 1'b1;
					nxt_s.idx = 4'h0;
					nxt_s.bitc = 6'h00;
				end
				A_REF, A_ACT: begin
					nxt_s.vals[V_REF] = ref_new;
					nxt_s.vals[V_TGT] = $signed(s_ff.vals[V_TGT]) + delta;
					nxt_s.vals[V_END] = $signed(s_ff.vals[V_END]) + delta;
					nxt_s.vals[V_ULIM] = $signed(s_ff.vals[V_ULIM]) + delta;
					nxt_s.vals[V_LLIM] = $signed(s_ff.vals[V_LLIM]) + delta;
				end
				A_END: begin
					nxt_s.vals[V_END] = pwdata;
					nxt_s.vals[V_ULIM] = $signed(pwdata) - rot3;
					nxt_s.vals[V_LLIM] = $signed(pwdata) - rot253;
				end
				A_ULIM: nxt_s.vals[V_ULIM] = pwdata;
				A_LLIM: nxt_s.vals[V_LLIM] = pwdata;
				A_WIN: nxt_s.vals[V_WIN] = pwdata;
				A_LOOP: nxt_s.vals[V_LOOP] = pwdata;
				A_THR: nxt_s.vals[V_THR] = pwdata;
				A_CORR: nxt_s.corr = pwdata[15:0];
				A_TGT: begin
					if ($signed(pwdata) > $signed(s_ff.vals[V_ULIM])) nxt_s.vals[V_TGT] = s_ff.vals[V_ULIM];
					else if ($signed(pwdata) < $signed(s_ff.vals[V_LLIM]))
						nxt_s.vals[V_TGT] = s_ff.vals[V_LLIM];
					else nxt_s.vals[V_TGT] = pwdata;
				end
				A_SAVE: if (pwdata[0]) nxt_s.save_busy = 1'b1;
				A_FAULT: nxt_s.fault = pwdata[1:0];
				A_BDLY: nxt_s.bdly = pwdata[15:0];
				A_SPCT: nxt_s.spct = pwdata[7:0];
				A_SMS: nxt_s.sms = pwdata[15:0];
				A_BTYPE: nxt_s.btype = apm_brake_type'(pwdata[1:0]);
				default: nxt_s.ctrl = s_ff.ctrl;
			endcase
		end
		// restoring divider, one quotient bit per cycle
		if (s_ff.busy) begin
			if (s_ff.idx == 4'h9) begin
				// settle cycle: read data captured before ready rises holds the new values
				nxt_s.busy = 1'b0;
			end else if (s_ff.bitc == 6'h00) begin
				nxt_s.dq = 46'(div_mag) * 46'(div_mul);
				nxt_s.rem = 14'h0000;
				nxt_s.neg = div_src[31];
				nxt_s.bitc = 6'h01;
			end else if (s_ff.bitc <= DIV_STEPS) begin
				if (trial >= {1'b0, div_den}) begin
					nxt_s.rem = 14'(trial - {1'b0, div_den});
					nxt_s.dq = {s_ff.dq[44:0], 1'b1};
				end else begin
					nxt_s.rem = trial[13:0];
					nxt_s.dq = {s_ff.dq[44:0], 1'b0};
				end
				nxt_s.bitc = s_ff.bitc + 6'h01;
			end else begin
				nxt_s.bitc = 6'h00;
				if (s_ff.idx == 4'h8) begin
					nxt_s.spr = s_ff.dq[31:0];
					nxt_s.idx = 4'h9;
				end else begin
					nxt_s.vals[s_ff.idx[2:0]] = s_ff.neg ? 32'(-s_ff.dq[31:0]) : s_ff.dq[31:0];
					nxt_s.idx = s_ff.idx + 4'h1;
				end
			end
		end
		if ((s_ff.rs == RS_RUN) && stall_low) begin
			if (s_ff.mscnt == 32'h0000_0000 && s_ff.stall_ms != 16'hFFFF) nxt_s.stall_ms = s_ff.stall_ms + 16'h0001;
		end else begin
			nxt_s.stall_ms = 16'h0000;
		end
		if (drag_on && (s_ff.vals[V_THR] != 32'h0000_0000) && (adiff > $signed(s_ff.vals[V_THR]))) begin
			nxt_s.drag_err = 1'b1;
		end
		if (drag_on && (s_ff.corr != 16'h0000)) begin
			if (spd_sum < 0) nxt_s.speed = 16'h0000;
			else if (spd_sum > 34'sh0_FFFF) nxt_s.speed = 16'hFFFF;
			else nxt_s.speed = spd_sum[15:0];
		end else begin
			nxt_s.speed = tgt_speed_i;
		end
		nxt_s.cnt = s_ff.cnt + 32'h0000_0001;
		case (s_ff.rs)
			RS_IDLE: begin
				// a pending command restarts once valid
				if (run_req && !abort && !s_ff.busy) begin
					nxt_s.cnt = 32'h0000_0000;
					nxt_s.rs = (s_ff.btype == BK_NONE) ? RS_RUN : RS_WAIT;
				end
			end
			RS_WAIT: begin
				if (abort) nxt_s.rs = RS_IDLE;
				else if (s_ff.cnt >= 32'(BWAIT_CYC - 1)) begin
					// back off after short wait, idle then run
					nxt_s.rs = (s_ff.btype == BK_HOLD) ? RS_UNLK : RS_RUN;
					nxt_s.bk_start = phys_pos_i;
				end
			end
			RS_UNLK: begin
				if (abort) nxt_s.rs = RS_IDLE;
				else if ($signed(phys_pos_i - $signed(s_ff.bk_start)) >= $signed(32'(BACKOFF)) ||
					$signed($signed(s_ff.bk_start) - phys_pos_i) >= $signed(32'(BACKOFF)))
					nxt_s.rs = RS_RUN;
			end
			RS_RUN: begin
				if (abort || motion_done_i) begin
					if ((s_ff.stall_ms > s_ff.sms) && stall_low) nxt_s.pos_err = 1'b1;
					nxt_s.cnt = 32'h0000_0000;
					nxt_s.rs = (s_ff.btype == BK_HOLD) ? RS_HOLD : RS_IDLE;
				end
			end
			RS_HOLD: begin
				if (s_ff.mscnt == 32'h0000_0000) nxt_s.cnt = s_ff.cnt + 32'h0000_0001;
				else nxt_s.cnt = s_ff.cnt;
				if (run_req && !abort && !s_ff.busy) nxt_s.rs = RS_RUN;
				else if (s_ff.cnt >= 32'(s_ff.bdly)) nxt_s.rs = RS_IDLE;
			end
			default: nxt_s.rs = RS_IDLE;
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_ff <= '0;
			s_ff.num <= FACT_DEF;
			s_ff.den <= FACT_DEF;
			s_ff.vals[V_REF] <= 32'h0000_0000;
			s_ff.vals[V_TGT] <= TGT_DEF;
			s_ff.vals[V_END] <= END_DEF;
			s_ff.vals[V_ULIM] <= ULIM_DEF;
			s_ff.vals[V_LLIM] <= LLIM_DEF;
			s_ff.vals[V_WIN] <= WIN_DEF;
			s_ff.vals[V_LOOP] <= LOOP_DEF;
			s_ff.vals[V_THR] <= THR_DEF;
			s_ff.spr <= SPR_BASE;
			s_ff.fault <= FLT_ABORT;
			s_ff.bdly <= BDLY_MS;
			s_ff.spct <= SPCT_DEF;
			s_ff.sms <= SMS_DEF;
			s_ff.rs <= RS_IDLE;
			s_ff.btype <= BK_NONE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign run_o = (s_ff.rs == RS_RUN);
	assign reverse_o = (s_ff.rs == RS_UNLK);
	// friction brake applied only in the wait and the run
	assign brake_engage_o = (s_ff.btype == BK_HOLD) ? ((s_ff.rs == RS_IDLE) || (s_ff.rs == RS_WAIT)) :
		(s_ff.btype == BK_FRIC) ? ((s_ff.rs == RS_WAIT) || (s_ff.rs == RS_RUN)) : 1'b0;
	assign save_req_o = s_ff.save_busy;
	assign speed_cmd_o = s_ff.speed;
	assign target_o = s_ff.vals[V_TGT];

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_end_limits: assert property (wr && paddr == A_END |=>
		$signed(s_ff.vals[V_ULIM]) == $signed($past(pwdata)) - rot3) else $error("upper limit not derived");
	a_dir_restore: assert property (wr && paddr == A_DIR && pwdata[0] != s_ff.dir |=>
		s_ff.vals[V_REF] == 32'h0000_0000 && s_ff.vals[V_END] == END_DEF) else $error("direction did not restore");
	a_ref_shift: assert property (wr && paddr == A_REF |=>
		s_ff.vals[V_END] == $past(s_ff.vals[V_END]) + $past(delta)) else $error("end not shifted");
	a_tgt_clamp: assert property (wr && paddr == A_TGT && $signed(pwdata) > $signed(s_ff.vals[V_ULIM]) |=>
		s_ff.vals[V_TGT] == $past(s_ff.vals[V_ULIM])) else $error("target not clamped");
	a_save_done: assert property (s_ff.save_busy && save_done_i && !(wr && paddr == A_SAVE && pwdata[0]) |=>
		!s_ff.save_busy) else $error("save stuck");
	a_spr_value: assert property ($fell(s_ff.busy) |->
		s_ff.spr == (32'd400 * 32'(s_ff.num)) / 32'(s_ff.den)) else $error("steps per rev wrong");
	a_fact_range: assert property (s_ff.num >= 14'h0001 && s_ff.num <= FACT_MAX &&
		s_ff.den >= 14'h0001 && s_ff.den <= FACT_MAX) else $error("factor out of range");
	a_drag_off: assert property (s_ff.vals[V_THR] == 32'h0000_0000 && !s_ff.drag_err &&
		!(wr && paddr == A_THR) |=> !s_ff.drag_err) else $error("drag flagged while disabled");
	a_drag_brake: assert property (braking_i && !s_ff.drag_err |=> !s_ff.drag_err) else $error("drag during brake");
	a_timeout_abort: assert property (run_o && comm_timeout_i && s_ff.fault == FLT_ABORT |=> !run_o)
		else $error("timeout did not abort");
	a_hold_brake: assert property (s_ff.btype == BK_HOLD && run_o |-> !brake_engage_o)
		else $error("holding brake applied in run");
	c_rescale: cover property ($fell(s_ff.busy));
	c_stall: cover property ($rose(s_ff.pos_err));
	c_drag: cover property ($rose(s_ff.drag_err));
	c_hold_end: cover property (s_ff.rs == RS_HOLD ##1 s_ff.rs == RS_IDLE);
endmodule

// *** apm_master.sv ***
// Purpose: fieldbus controller model acting as APB master
// Assumes: one transfer at a time, answer awaited under a bound
// Notes: xfer is called from the bench; ok low means no answer came
`timescale 1ns/1ps
module apm_master (
	input wire logic clk_i, // clock
	input wire logic pready_i, // apb ready
	input wire logic [31:0] prdata_i, // apb read data
	input wire logic pslverr_i, // apb error
	output logic psel_o, // apb select
	output logic penable_o, // apb enable
	output logic pwrite_o, // apb direction
	output logic [7:0] paddr_o, // apb address
	output logic [31:0] pwdata_o // apb write data
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic ok);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		ok = 1'b0;
		// request held until ready is sampled high
		while (!ok && n < 2000) begin
			@(posedge clk_i);
			ok = (pready_i === 1'b1);
			n++;
		end
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule

// *** tb_apm_core.sv ***
// Purpose: self-checking bench of the position mapping monitor
// Assumes: MS_CYC shortened to 10 cycles
// Notes: table rows first, then refusal, save, run and reset cases
`timescale 1ns/1ps
module tb_apm_core import apm_pkg::*;;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} apm_row_type;
	localparam logic [31:0] E = 32'h0002_0000;
	localparam logic [31:0] R3 = 3 * SPR_BASE;
	localparam logic [31:0] R253 = 253 * SPR_BASE;
	localparam apm_row_type ROWS [19] = '{
		'{1'b0, A_NUM, 32'h0000_0190}, '{1'b0, A_DEN, 32'h0000_0190},
		'{1'b0, A_REF, 32'h0000_0000}, '{1'b0, A_END, END_DEF},
		'{1'b0, A_ULIM, END_DEF - R3}, '{1'b0, A_LLIM, END_DEF - R253},
		'{1'b1, A_END, E}, '{1'b0, A_ULIM, E - R3}, '{1'b0, A_LLIM, E - R253},
		'{1'b1, A_REF, 32'h0000_0064}, '{1'b0, A_END, E + 32'h0000_0064},
		'{1'b1, A_DIR, 32'h0000_0001}, '{1'b0, A_REF, 32'h0000_0000},
		'{1'b0, A_END, END_DEF}, '{1'b0, A_LLIM, END_DEF - R253},
		'{1'b1, A_NUM, 32'h0000_0320}, '{1'b0, A_SPR, 32'h0000_0320},
		'{1'b0, A_END, END_DEF * 2}, '{1'b1, A_NUM, 32'h0000_0190}};
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic signed [31:0] phys_pos_i = '0, cmd_pos_i = '0, target_o;
	logic [15:0] speed_i = 16'h0064, tgt_speed_i = 16'h0064, speed_cmd_o;
	logic braking_i = 1'b0, motion_done_i = 1'b0, comm_timeout_i = 1'b0, save_done_i = 1'b0;
	logic run_o, reverse_o, brake_engage_o, save_req_o, er, ok;
	int num_errors = 0, compares = 0;
	always #12.5 clk_i = ~clk_i;
	apm_core #(.MS_CYC(10)) apm_core_i (.clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .phys_pos_i, .cmd_pos_i, .speed_i, .tgt_speed_i,
		.braking_i, .motion_done_i, .comm_timeout_i, .save_done_i, .run_o, .reverse_o,
		.brake_engage_o, .save_req_o, .speed_cmd_o, .target_o);
	apm_master apm_master_i (.clk_i, .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	task automatic summarize();
		if (num_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		apm_master_i.xfer(w, a, d, rd, er, ok);
		if (!ok) begin
			num_errors++;
			summarize();
		end
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		bus(1'b0, a, '0);
		while ((rd & m) !== v && n < 50) begin
			bus(1'b0, a, '0);
			n++;
		end
		chk("poll", v, rd & m);
	endtask
	task automatic wait_run(input logic v);
		int n;
		n = 0;
		while (run_o !== v && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk("run_o", {31'h0, v}, {31'h0, run_o});
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		// parameters written in the documented order
		foreach (ROWS[i]) begin
			bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
			if (!ROWS[i].w) chk($sformatf("reg %h", ROWS[i].a), ROWS[i].d, rd);
		end
		bus(1'b1, A_NUM, 32'h0000_2711);
		chk("num refused", 32'h1, {31'h0, er});
		bus(1'b1, A_DEN, 32'h0000_2710);
		chk("den accepted", 32'h0, {31'h0, er});
		bus(1'b0, A_SPR, '0);
		chk("steps", 32'h0000_0010, rd);
		bus(1'b1, A_DEN, 32'h0000_0190);
		bus(1'b0, 8'h80, '0);
		chk("unmapped", 32'h1, {31'h0, er});
		phys_pos_i <= 32'h0000_0064;
		bus(1'b1, A_ACT, 32'h0000_01F4);
		bus(1'b0, A_REF, '0);
		chk("offset", 32'h0000_0190, rd);
		bus(1'b1, A_TGT, 32'h0010_0000);
		bus(1'b0, A_TGT, '0);
		chk("target clamp", END_DEF - R3 + 32'h0000_0190, rd);
		chk("target_o", END_DEF - R3 + 32'h0000_0190, target_o);
		bus(1'b1, A_SAVE, 32'h0000_0001);
		bus(1'b0, A_SAVE, '0);
		chk("save busy", 32'h0000_0001, rd);
		chk("save_req", 32'h0000_0001, {31'h0, save_req_o});
		save_done_i <= 1'b1;
		poll(A_SAVE, 32'hFFFF_FFFF, 32'h0000_0000);
		save_done_i <= 1'b0;
		cmd_pos_i <= 32'h0000_1000;
		braking_i <= 1'b1;
		bus(1'b1, A_CTRL, 32'h0000_0011);
		poll(A_STAT, 32'h1 << S_MOVE, 32'h1 << S_MOVE);
		wait_run(1'b1);
		bus(1'b0, A_STAT, '0);
		chk("drag braking", 32'h0, rd & (32'h1 << S_DRAG));
		braking_i <= 1'b0;
		bus(1'b0, A_STAT, '0);
		chk("drag", 32'h1 << S_DRAG, rd & (32'h1 << S_DRAG));
		chk("speed", {16'h0, tgt_speed_i}, {16'h0, speed_cmd_o});
		bus(1'b1, A_CORR, 32'h0000_0100);
		repeat (2) @(posedge clk_i);
		chk("speed corr", 32'h0000_0E70, {16'h0, speed_cmd_o});
		motion_done_i <= 1'b1;
		wait_run(1'b0);
		bus(1'b1, A_CTRL, '0);
		motion_done_i <= 1'b0;
		bus(1'b1, A_CTRL, 32'h0000_0011);
		wait_run(1'b1);
		comm_timeout_i <= 1'b1;
		wait_run(1'b0);
		bus(1'b1, A_CTRL, '0);
		comm_timeout_i <= 1'b0;
		bus(1'b1, A_BTYPE, 32'h0000_0001);
		bus(1'b1, A_BDLY, 32'h0000_0002);
		bus(1'b1, A_CTRL, 32'h0000_0011);
		chk("brake before run", 32'h1, {31'h0, brake_engage_o});
		for (int n = 0; n < 1000 && reverse_o !== 1'b1; n++) @(posedge clk_i);
		chk("back-off", 32'h1, {31'h0, reverse_o});
		phys_pos_i <= 32'h0000_0060;
		wait_run(1'b1);
		chk("brake in run", 32'h0, {31'h0, brake_engage_o});
		bus(1'b1, A_CTRL, '0);
		repeat (2) @(posedge clk_i);
		chk("brake held off", 32'h0, {31'h0, brake_engage_o});
		for (int n = 0; n < 100 && brake_engage_o !== 1'b1; n++) @(posedge clk_i);
		chk("brake after delay", 32'h1, {31'h0, brake_engage_o});
		bus(1'b1, A_BTYPE, 32'h0000_0002);
		bus(1'b1, A_CTRL, 32'h0000_0011);
		repeat (2) @(posedge clk_i);
		chk("friction idle", 32'h1, {31'h0, brake_engage_o & ~run_o});
		for (int n = 0; n < 1000 && run_o !== 1'b1; n++) @(posedge clk_i);
		wait_run(1'b1);
		bus(1'b1, A_CTRL, '0);
		repeat (2) @(posedge clk_i);
		chk("friction released", 32'h0, {31'h0, brake_engage_o});
		resetn_i <= 1'b0;
		@(posedge clk_i);
		chk("reset target", TGT_DEF, target_o);
		resetn_i <= 1'b1;
		bus(1'b0, A_REF, '0);
		chk("reset offset", 32'h0000_0000, rd);
		summarize();
	end
endmodule
